// ### rtl/ppc_pkg.sv
// Constants for the port and pin control block
package ppc_pkg;
    localparam int PORT_A_WIDTH   = 4;
    localparam int PORT_B_WIDTH   = 2;
    localparam int KEY_WIDTH      = 4;
    localparam int MIXED_WIDTH    = 2;
    localparam int SEG_WIDTH      = 6;
    localparam int SEG_FIRST      = 17;
    localparam int SEG_LAST       = 22;
    localparam int MIXED_TIMER_BIT = 0;
    localparam int MIXED_INTR_BIT  = 1;
    // Pull-up option bit positions for port A, port B and the key port
    localparam int PU_PORT_A      = 0;
    localparam int PU_PORT_B      = 1;
    localparam int PU_KEY         = 2;
    localparam int PU_WIDTH       = 3;
    // Reset values
    localparam logic [3:0] DIR_A_RESET   = 4'hF;
    localparam logic [1:0] DIR_B_RESET   = 2'h3;
    localparam logic [3:0] DIR_K_RESET   = 4'hF;
    localparam logic [1:0] DIR_M_RESET   = 2'h3;
    localparam logic [2:0] PU_RESET      = 3'h0;
    localparam logic [5:0] SEG_FN_RESET  = 6'h0;
    // Edge selection for the external interrupt
    typedef enum logic [1:0] {
        PPC_EDGE_RISE = 2'h0,
        PPC_EDGE_FALL = 2'h1,
        PPC_EDGE_BOTH = 2'h3
    } ppc_edge_t;
endpackage : ppc_pkg

// ### rtl/ppc_edge_if.sv
// Interface between the port block and its edge detector
`timescale 1ns/1ps
`default_nettype none
interface ppc_edge_if;
    logic               level;
    ppc_pkg::ppc_edge_t edgeSel;
    logic               enable;
    logic               pulse;
    modport detector (input level, input edgeSel, input enable, output pulse);
    modport user     (output level, output edgeSel, output enable, input pulse);
endinterface : ppc_edge_if
`default_nettype wire

// ### rtl/ppc_edge_detect.sv
// Edge detector for the external interrupt input
`timescale 1ns/1ps
`default_nettype none
module ppc_edge_detect (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   resetn,
    // Detector link
    ppc_edge_if.detector ed
);
    logic prevReg;
    logic pulseReg;
    wire  riseSeen = ed.level & ~prevReg;
    wire  fallSeen = ~ed.level & prevReg;
    wire  hit      = ed.enable & (
                       (ed.edgeSel == ppc_pkg::PPC_EDGE_RISE && riseSeen) ||
                       (ed.edgeSel == ppc_pkg::PPC_EDGE_FALL && fallSeen) ||
                       (ed.edgeSel == ppc_pkg::PPC_EDGE_BOTH && (riseSeen | fallSeen)));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prevReg  <= 1'b0;
            pulseReg <= 1'b0;
        end else begin
            prevReg  <= ed.level;
            pulseReg <= hit;
        end
    end
    assign ed.pulse = pulseReg;

    a_rise_detect: assert property (@(posedge clk) disable iff (!resetn)
        ed.enable && ed.edgeSel == ppc_pkg::PPC_EDGE_RISE && riseSeen |=> ed.pulse)
        else $error("rising edge missed");
    a_fall_only: assert property (@(posedge clk) disable iff (!resetn)
        ed.edgeSel == ppc_pkg::PPC_EDGE_FALL && riseSeen |=> !ed.pulse)
        else $error("rising edge taken in falling mode");
endmodule : ppc_edge_detect
`default_nettype wire

// ### rtl/ppc_port_control.sv
// Port pin control: five ports with direction and alternate functions, pull-ups on port A, port B and the key port
// Summary of operation
// - Port A has four bits, each direction set by its own direction bit.
// - Pull-ups enabled per port by option register, only while port is input.
// - Port B has two bits with per-bit direction register.
// - Key port has four bits, each direction set per bit in port mode.
// - Key port pull-ups on when pull-up option or key-return mode asks.
// - Each key bit is either port bit or key-return detection input.
// - Mixed port: per-bit direction; control mode gives timer out, interrupt/analog.
// - External interrupt edge selectable: rising, falling or both.
// - Segment port bits select input or segment output, bit 0 is segment 22.
// - Segment port never drives pins as port outputs.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_control #(
    parameter int PORT_A_W = ppc_pkg::PORT_A_WIDTH,
    parameter int PORT_B_W = ppc_pkg::PORT_B_WIDTH,
    parameter int KEY_W    = ppc_pkg::KEY_WIDTH,
    parameter int SEG_W    = ppc_pkg::SEG_WIDTH
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // Configuration writes (direction 1 = input)
    input  wire logic                cfgWrite,
    input  wire logic [PORT_A_W-1:0] portADirectionIn,
    input  wire logic [PORT_B_W-1:0] portBDirectionIn,
    input  wire logic [KEY_W-1:0]    keyPortDirectionIn,
    input  wire logic [1:0]          mixedPortDirectionIn,
    input  wire logic [2:0]          pullupOptionIn,
    input  wire logic                keyReturnModeIn,
    input  wire logic [KEY_W-1:0]    keyControlModeIn,
    input  wire logic [1:0]          mixedControlModeIn,
    input  wire logic [1:0]          edgeSelectIn,
    input  wire logic [SEG_W-1:0]    segmentPortFunctionIn,
    // Output latch writes
    input  wire logic                dataWrite,
    input  wire logic [PORT_A_W-1:0] portADataIn,
    input  wire logic [PORT_B_W-1:0] portBDataIn,
    input  wire logic [KEY_W-1:0]    keyPortDataIn,
    input  wire logic [1:0]          mixedPortDataIn,
    // Alternate function sources from peripherals
    input  wire logic                timerOutput,
    input  wire logic [22:17]        sharedSegmentOutputs,
    // Pin inputs
    input  wire logic [PORT_A_W-1:0] portAPinsIn,
    input  wire logic [PORT_B_W-1:0] portBPinsIn,
    input  wire logic [KEY_W-1:0]    keyPortPinsIn,
    input  wire logic                mixedPortBit0In,
    input  wire logic                mixedPortBit1In,
    input  wire logic [SEG_W-1:0]    segmentPortPinsIn,
    // Pin outputs and enables
    output logic [PORT_A_W-1:0]      portAPinsOut,
    output logic [PORT_A_W-1:0]      portAPinsOe,
    output logic [PORT_B_W-1:0]      portBPinsOut,
    output logic [PORT_B_W-1:0]      portBPinsOe,
    output logic [KEY_W-1:0]         keyPortPinsOut,
    output logic [KEY_W-1:0]         keyPortPinsOe,
    output logic                     mixedPortBit0Out,
    output logic                     mixedPortBit0Oe,
    output logic                     mixedPortBit1Out,
    output logic                     mixedPortBit1Oe,
    output logic [SEG_W-1:0]         segmentPortPinsOut,
    output logic [SEG_W-1:0]         segmentPortPinsOe,
    // Pull-up enables
    output logic [PORT_A_W-1:0]      portAPullup,
    output logic [PORT_B_W-1:0]      portBPullup,
    output logic [KEY_W-1:0]         keyPortPullup,
    // Data read back
    output logic [PORT_A_W-1:0]      portARead,
    output logic [PORT_B_W-1:0]      portBRead,
    output logic [KEY_W-1:0]         keyPortRead,
    output logic [1:0]               mixedPortRead,
    output logic [SEG_W-1:0]         segmentPortRead,
    // Peripheral side
    output logic [KEY_W-1:0]         keyReturnInputs,
    output logic                     externalInterruptInput,
    output logic                     externalInterruptPulse,
    output logic                     analogInputPin
);
    // Elaboration check: the pin map fixes every width
    if (PORT_A_W != ppc_pkg::PORT_A_WIDTH || PORT_B_W != ppc_pkg::PORT_B_WIDTH ||
        KEY_W != ppc_pkg::KEY_WIDTH || SEG_W != ppc_pkg::SEG_WIDTH) begin : g_width_check
        $error("port widths are fixed by the pin map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [PORT_A_W-1:0] portADirection_reg;
    logic [PORT_B_W-1:0] portBDirection_reg;
    logic [KEY_W-1:0]    keyPortDirection_reg;
    logic [1:0]          mixedPortDirection_reg;
    logic [2:0]          pullupOption_reg;
    logic                keyReturnMode_reg;
    logic [KEY_W-1:0]    keyControl_reg;
    logic [1:0]          mixedControl_reg;
    ppc_pkg::ppc_edge_t  edgeSel_reg;
    logic [SEG_W-1:0]    segmentPortFunction_reg;
    logic [PORT_A_W-1:0] portALatch_reg;
    logic [PORT_B_W-1:0] portBLatch_reg;
    logic [KEY_W-1:0]    keyLatch_reg;
    logic [1:0]          mixedLatch_reg;

    // Unused edge code 2 falls back to both edges
    wire ppc_pkg::ppc_edge_t edgeSel_next = (edgeSelectIn == 2'h0) ? ppc_pkg::PPC_EDGE_RISE :
                                            (edgeSelectIn == 2'h1) ? ppc_pkg::PPC_EDGE_FALL :
                                            ppc_pkg::PPC_EDGE_BOTH;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            portADirection_reg      <= ppc_pkg::DIR_A_RESET;
            portBDirection_reg      <= ppc_pkg::DIR_B_RESET;
            keyPortDirection_reg    <= ppc_pkg::DIR_K_RESET;
            mixedPortDirection_reg  <= ppc_pkg::DIR_M_RESET;
            pullupOption_reg        <= ppc_pkg::PU_RESET;
            keyReturnMode_reg       <= 1'b0;
            keyControl_reg          <= 4'h0;
            mixedControl_reg        <= 2'h0;
            edgeSel_reg             <= ppc_pkg::PPC_EDGE_RISE;
            segmentPortFunction_reg <= ppc_pkg::SEG_FN_RESET;
        end else if (cfgWrite) begin
            portADirection_reg      <= portADirectionIn;
            portBDirection_reg      <= portBDirectionIn;
            keyPortDirection_reg    <= keyPortDirectionIn;
            mixedPortDirection_reg  <= mixedPortDirectionIn;
            pullupOption_reg        <= pullupOptionIn;
            keyReturnMode_reg       <= keyReturnModeIn;
            keyControl_reg          <= keyControlModeIn;
            mixedControl_reg        <= mixedControlModeIn;
            edgeSel_reg             <= edgeSel_next;
            segmentPortFunction_reg <= segmentPortFunctionIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            portALatch_reg <= 4'h0;
            portBLatch_reg <= 2'h0;
            keyLatch_reg   <= 4'h0;
            mixedLatch_reg <= 2'h0;
        end else if (dataWrite) begin
            portALatch_reg <= portADataIn;
            portBLatch_reg <= portBDataIn;
            keyLatch_reg   <= keyPortDataIn;
            mixedLatch_reg <= mixedPortDataIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin decode
    wire [1:0]       mixedPinsIn = {mixedPortBit1In, mixedPortBit0In};
    wire [KEY_W-1:0] keyPortMode = ~keyControl_reg;
    wire             timerSel    = mixedControl_reg[ppc_pkg::MIXED_TIMER_BIT];
    wire             mixedOut0   = timerSel ? timerOutput : mixedLatch_reg[0];
    wire             mixedOe0    = timerSel | ~mixedPortDirection_reg[0];
    // Bit 1 alternates are inputs only, so control mode releases the pin
    wire             mixedOe1    = ~mixedControl_reg[1] & ~mixedPortDirection_reg[1];
    wire             puA = pullupOption_reg[ppc_pkg::PU_PORT_A];
    wire             puB = pullupOption_reg[ppc_pkg::PU_PORT_B];
    wire             puK = pullupOption_reg[ppc_pkg::PU_KEY] | keyReturnMode_reg;
    wire [SEG_W-1:0] segDrive;
    wire [SEG_W-1:0] segCtrl = segmentPortFunction_reg;
    wire [KEY_W-1:0] keyOe   = keyPortMode & ~keyPortDirection_reg;

    genvar gi;
    generate
        for (gi = 0; gi < SEG_W; gi++) begin : g_seg
            assign segDrive[gi] = sharedSegmentOutputs[ppc_pkg::SEG_LAST - gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // External interrupt edge detector
    ppc_edge_if edgeLink ();
    assign edgeLink.level   = mixedPortBit1In;
    assign edgeLink.edgeSel = edgeSel_reg;
    assign edgeLink.enable  = mixedControl_reg[ppc_pkg::MIXED_INTR_BIT];

    ppc_edge_detect u_edge (
        .clk    (clk),
        .resetn (resetn),
        .ed     (edgeLink.detector)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            portAPinsOut <= 4'h0;
            portAPinsOe <= 4'h0;
            portBPinsOut <= 2'h0;
            portBPinsOe <= 2'h0;
            keyPortPinsOut <= 4'h0;
            keyPortPinsOe <= 4'h0;
            mixedPortBit0Out <= 1'b0;
            mixedPortBit0Oe <= 1'b0;
            mixedPortBit1Out <= 1'b0;
            mixedPortBit1Oe <= 1'b0;
            segmentPortPinsOut <= 6'h0;
            segmentPortPinsOe <= 6'h0;
            portAPullup <= 4'h0;
            portBPullup <= 2'h0;
            keyPortPullup <= 4'h0;
            portARead <= 4'h0;
            portBRead <= 2'h0;
            keyPortRead <= 4'h0;
            mixedPortRead <= 2'h0;
            segmentPortRead <= 6'h0;
            keyReturnInputs <= 4'h0;
            externalInterruptInput <= 1'b0;
            externalInterruptPulse <= 1'b0;
            analogInputPin <= 1'b0;
        end else begin
            portAPinsOut <= portALatch_reg;
            portAPinsOe <= ~portADirection_reg;
            portBPinsOut <= portBLatch_reg;
            portBPinsOe <= ~portBDirection_reg;
            keyPortPinsOut <= keyLatch_reg;
            keyPortPinsOe <= keyOe;
            mixedPortBit0Out <= mixedOut0;
            mixedPortBit0Oe <= mixedOe0;
            mixedPortBit1Out <= mixedLatch_reg[1];
            mixedPortBit1Oe <= mixedOe1;
            segmentPortPinsOut <= segDrive & segCtrl;
            segmentPortPinsOe <= segCtrl;
            portAPullup <= {PORT_A_W{puA}} & portADirection_reg;
            portBPullup <= {PORT_B_W{puB}} & portBDirection_reg;
            keyPortPullup <= {KEY_W{puK}} & (keyPortDirection_reg | keyControl_reg);
            portARead <= (portADirection_reg & portAPinsIn) |
                         (~portADirection_reg & portALatch_reg);
            portBRead <= (portBDirection_reg & portBPinsIn) |
                         (~portBDirection_reg & portBLatch_reg);
            keyPortRead <= (keyPortDirection_reg & keyPortPinsIn) |
                           (~keyPortDirection_reg & keyLatch_reg);
            mixedPortRead <= (mixedPortDirection_reg & mixedPinsIn) |
                             (~mixedPortDirection_reg & mixedLatch_reg);
            segmentPortRead <= segmentPortPinsIn & ~segCtrl;
            keyReturnInputs <= keyPortPinsIn & keyControl_reg;
            externalInterruptInput <= mixedPortBit1In & mixedControl_reg[1];
            externalInterruptPulse <= edgeLink.pulse;
            analogInputPin <= mixedPortBit1In & mixedControl_reg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_seg_never_port: assert property (@(posedge clk) disable iff (!resetn)
        (segmentPortPinsOe & ~$past(segCtrl)) == 6'h0)
        else $error("segment port driven in port mode");
    a_pullup_input_only: assert property (@(posedge clk) disable iff (!resetn)
        (portAPullup & ~$past(portADirection_reg)) == 4'h0)
        else $error("pull-up on output bit");
    a_key_pullup_mode: assert property (@(posedge clk) disable iff (!resetn)
        keyReturnMode_reg && keyPortDirection_reg == 4'hF |=> keyPortPullup == 4'hF)
        else $error("key return mode did not enable pull-ups");
    a_reset_inputs: assert property (@(posedge clk)
        !resetn |=> portADirection_reg == 4'hF && pullupOption_reg == 3'h0 &&
        segmentPortFunction_reg == 6'h0)
        else $error("reset state wrong");
    a_read_latch: assert property (@(posedge clk) disable iff (!resetn)
        portADirection_reg == 4'h0 |=> portARead == $past(portALatch_reg))
        else $error("output bit read not from latch");
    a_read_pin: assert property (@(posedge clk) disable iff (!resetn)
        portBDirection_reg == 2'h3 |=> portBRead == $past(portBPinsIn))
        else $error("input bit read not from pin");
    a_timer_out: assert property (@(posedge clk) disable iff (!resetn)
        timerSel |=> mixedPortBit0Oe && mixedPortBit0Out == $past(timerOutput))
        else $error("timer output not on mixed bit 0");
    a_seg_order: assert property (@(posedge clk) disable iff (!resetn)
        segCtrl[0] |=> segmentPortPinsOut[0] == $past(sharedSegmentOutputs[22]))
        else $error("segment order wrong");
    a_key_oe_ctrl: assert property (@(posedge clk) disable iff (!resetn)
        (keyPortPinsOe & $past(keyControl_reg)) == 4'h0)
        else $error("key return bit driven");
    a_intr_pin_input: assert property (@(posedge clk) disable iff (!resetn)
        mixedControl_reg[ppc_pkg::MIXED_INTR_BIT] |=> !mixedPortBit1Oe)
        else $error("interrupt pin driven in control mode");
    a_mixed_bit1_out: assert property (@(posedge clk) disable iff (!resetn)
        !mixedControl_reg[1] && !mixedPortDirection_reg[1] |=>
        mixedPortBit1Oe && mixedPortBit1Out == $past(mixedLatch_reg[1]))
        else $error("mixed bit 1 output not driven");
    a_port_b_oe: assert property (@(posedge clk) disable iff (!resetn)
        portBPinsOe == ~$past(portBDirection_reg))
        else $error("port B enable not from direction");
    a_key_pull_input: assert property (@(posedge clk) disable iff (!resetn)
        (keyPortPullup & ~$past(keyPortDirection_reg | keyControl_reg)) == 4'h0)
        else $error("key pull-up on output bit");
    a_edge_to_out: assert property (@(posedge clk) disable iff (!resetn)
        edgeLink.pulse |=> externalInterruptPulse)
        else $error("interrupt pulse lost");
    a_reset_drivers: assert property (@(posedge clk)
        !resetn |=> portAPinsOe == 4'h0 && keyPortPinsOe == 4'h0 && !mixedPortBit1Oe &&
        segmentPortPinsOe == 6'h0)
        else $error("pin driven after reset");
endmodule : ppc_port_control
`default_nettype wire

// ### test/ppc_pin_model.sv
// Board-side pin model: drives each pin, or follows the device while it drives
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model #(
    parameter int W = 4
) (
    // Clock
    input  wire logic         clk,
    // Device side
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] drv,
    input  wire logic [W-1:0] pull,
    // Board side
    input  wire logic [W-1:0] extEn,
    input  wire logic [W-1:0] extVal,
    output logic      [W-1:0] pin
);
    logic [W-1:0] last_reg = '0;
    // A released line without pull-up shows the inverse of its last level
    assign pin = (oe & drv) | (~oe & extEn & extVal) | (~oe & ~extEn & (pull | ~last_reg));
    always_ff @(posedge clk) begin
        last_reg <= pin;
    end
endmodule // ppc_pin_model
`default_nettype wire

// ### test/port_pin_control_tb_top.sv
// Self-checking bench for the port pin control block
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_tb_top;
    logic       clk = 1'b0, resetn = 1'b0, cfgWrite = 1'b0, dataWrite = 1'b0;
    logic       keyReturnModeIn = 1'b0, timerOutput = 1'b0;
    logic [3:0] portADirectionIn = 4'hF, keyPortDirectionIn = 4'hF, keyControlModeIn = 4'h0;
    logic [3:0] portADataIn = 4'h0, keyPortDataIn = 4'h0, extA = 4'h0, extK = 4'h0, enA = 4'hF;
    logic [1:0] portBDirectionIn = 2'h3, mixedPortDirectionIn = 2'h3, mixedControlModeIn = 2'h0;
    logic [1:0] edgeSelectIn = 2'h0, portBDataIn = 2'h0, mixedPortDataIn = 2'h0;
    logic [1:0] extB = 2'h0, extM = 2'h0;
    logic [1:0] enB = 2'h3, enM = 2'h3;
    logic [3:0] enK = 4'hF;
    logic [5:0] enS = 6'h3F;
    logic       mixedPortBit1Out, mixedPortBit1Oe;
    logic [2:0] pullupOptionIn = 3'h0;
    logic [5:0] segmentPortFunctionIn = 6'h0, sharedSegmentOutputs = 6'h0, extS = 6'h0;
    logic [3:0] portAPinsIn, keyPortPinsIn, portAPinsOut, portAPinsOe, keyPortPinsOut;
    logic [3:0] keyPortPinsOe, portAPullup, keyPortPullup, portARead, keyPortRead;
    logic [3:0] keyReturnInputs;
    logic [1:0] portBPinsIn, portBPinsOut, portBPinsOe, portBPullup, portBRead, mixedPortRead;
    logic [5:0] segmentPortPinsIn, segmentPortPinsOut, segmentPortPinsOe, segmentPortRead;
    logic       mixedPortBit0In, mixedPortBit1In, mixedPortBit0Out, mixedPortBit0Oe;
    logic       externalInterruptInput, externalInterruptPulse, analogInputPin;
    int         bad_count = 0;
    int         num_checks = 0;
    int         edges[$] = '{0, 1, 2, 3};
    int         pulses;

    always #50 clk = ~clk;

    ppc_port_control i_dut (.clk, .resetn, .cfgWrite, .portADirectionIn, .portBDirectionIn,
        .keyPortDirectionIn, .mixedPortDirectionIn, .pullupOptionIn, .keyReturnModeIn,
        .keyControlModeIn, .mixedControlModeIn, .edgeSelectIn, .segmentPortFunctionIn,
        .dataWrite, .portADataIn, .portBDataIn, .keyPortDataIn, .mixedPortDataIn,
        .timerOutput, .sharedSegmentOutputs, .portAPinsIn, .portBPinsIn, .keyPortPinsIn,
        .mixedPortBit0In, .mixedPortBit1In, .segmentPortPinsIn, .portAPinsOut, .portAPinsOe,
        .portBPinsOut, .portBPinsOe, .keyPortPinsOut, .keyPortPinsOe, .mixedPortBit0Out,
        .mixedPortBit0Oe, .mixedPortBit1Out, .mixedPortBit1Oe, .segmentPortPinsOut,
        .segmentPortPinsOe, .portAPullup, .portBPullup,
        .keyPortPullup, .portARead, .portBRead, .keyPortRead, .mixedPortRead,
        .segmentPortRead, .keyReturnInputs, .externalInterruptInput,
        .externalInterruptPulse, .analogInputPin);

    ppc_pin_model #(.W(4)) i_pin_a (.clk, .oe(portAPinsOe), .drv(portAPinsOut),
        .pull(portAPullup), .extEn(enA), .extVal(extA), .pin(portAPinsIn));
    ppc_pin_model #(.W(2)) i_pin_b (.clk, .oe(portBPinsOe), .drv(portBPinsOut),
        .pull(portBPullup), .extEn(enB), .extVal(extB), .pin(portBPinsIn));
    ppc_pin_model #(.W(4)) i_pin_k (.clk, .oe(keyPortPinsOe), .drv(keyPortPinsOut),
        .pull(keyPortPullup), .extEn(enK), .extVal(extK), .pin(keyPortPinsIn));
    ppc_pin_model #(.W(1)) i_pin_m0 (.clk, .oe(mixedPortBit0Oe), .drv(mixedPortBit0Out),
        .pull(1'b0), .extEn(enM[0]), .extVal(extM[0]), .pin(mixedPortBit0In));
    ppc_pin_model #(.W(1)) i_pin_m1 (.clk, .oe(mixedPortBit1Oe), .drv(mixedPortBit1Out),
        .pull(1'b0), .extEn(enM[1]), .extVal(extM[1]), .pin(mixedPortBit1In));
    ppc_pin_model #(.W(6)) i_pin_s (.clk, .oe(segmentPortPinsOe), .drv(segmentPortPinsOut),
        .pull(6'h0), .extEn(enS), .extVal(extS), .pin(segmentPortPinsIn));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] e, input logic [7:0] a, input string n);
        num_checks++;
        if (a !== e) begin
            bad_count++;
            $display("Error at %0t %s expected %h got %h", $time, n, e, a);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Config and latches load on one edge; outputs settle two edges later
    task automatic apply();
        cfgWrite = 1'b1;
        dataWrite = 1'b1;
        tick(1);
        cfgWrite = 1'b0;
        dataWrite = 1'b0;
        tick(4);
    endtask

    task automatic check_idle();
        chk(8'h00, {portAPinsOe, portBPinsOe, mixedPortBit0Oe, mixedPortBit1Oe}, "oe");
        chk(8'h00, {keyPortPinsOe, portAPullup}, "oe k pu a");
        chk(8'h00, {portBPullup, keyPortPullup}, "pu bk");
        chk(8'h00, {segmentPortPinsOe}, "seg oe");
    endtask

    task automatic check_ports();
        logic [5:0] rev;
        logic [1:0] pM;
        for (int i = 0; i < 6; i++) begin
            rev[i] = sharedSegmentOutputs[5-i];
        end
        pM = {mixedPortBit1In, mixedPortBit0In};
        chk({~portADirectionIn}, portAPinsOe, "a oe");
        chk({portADataIn & ~portADirectionIn}, {portAPinsOut & portAPinsOe}, "a out");
        chk({portADirectionIn & {4{pullupOptionIn[0]}}}, portAPullup, "a pu");
        chk({(portAPinsIn & portADirectionIn) | (portADataIn & ~portADirectionIn)},
            portARead, "a rd");
        chk({~portBDirectionIn}, portBPinsOe, "b oe");
        chk({portBDataIn & ~portBDirectionIn}, {portBPinsOut & portBPinsOe}, "b out");
        chk({portBDirectionIn & {2{pullupOptionIn[1]}}}, portBPullup, "b pu");
        chk({(portBPinsIn & portBDirectionIn) | (portBDataIn & ~portBDirectionIn)},
            portBRead, "b rd");
        chk({~keyPortDirectionIn & ~keyControlModeIn}, keyPortPinsOe, "k oe");
        chk({keyPortDataIn & ~keyPortDirectionIn & ~keyControlModeIn},
            {keyPortPinsOut & keyPortPinsOe}, "k out");
        chk({(keyPortDirectionIn | keyControlModeIn) & {4{pullupOptionIn[2] | keyReturnModeIn}}},
            keyPortPullup, "k pu");
        chk({((keyPortPinsIn & keyPortDirectionIn) | (keyPortDataIn & ~keyPortDirectionIn))
            & ~keyControlModeIn}, {keyPortRead & ~keyControlModeIn}, "k rd");
        chk({keyPortPinsIn & keyControlModeIn}, {keyReturnInputs & keyControlModeIn},
            "k ret");
        chk({mixedControlModeIn[0] | ~mixedPortDirectionIn[0]}, mixedPortBit0Oe, "m oe");
        chk({~mixedControlModeIn[1] & ~mixedPortDirectionIn[1]}, mixedPortBit1Oe, "m1 oe");
        chk({mixedPortDataIn[1] & ~mixedControlModeIn[1] & ~mixedPortDirectionIn[1]},
            {mixedPortBit1Out & mixedPortBit1Oe}, "m1 out");
        if (mixedPortBit0Oe === 1'b1) begin
            chk(mixedControlModeIn[0] ? timerOutput : mixedPortDataIn[0], mixedPortBit0Out,
                "m out");
        end
        chk({((pM & mixedPortDirectionIn) | (mixedPortDataIn & ~mixedPortDirectionIn))
            & ~mixedControlModeIn}, {mixedPortRead & ~mixedControlModeIn}, "m rd");
        if (mixedControlModeIn[1] === 1'b1) begin
            chk({mixedPortBit1In, mixedPortBit1In}, {externalInterruptInput, analogInputPin},
                "m in");
        end
        chk(segmentPortFunctionIn, segmentPortPinsOe, "s oe");
        chk({rev & segmentPortFunctionIn}, {segmentPortPinsOut & segmentPortFunctionIn},
            "s out");
        chk({segmentPortPinsIn & ~segmentPortFunctionIn},
            {segmentPortRead & ~segmentPortFunctionIn}, "s rd");
    endtask

    task automatic count_pulses(input logic lvl, input logic e);
        extM[1] = lvl;
        pulses = 0;
        repeat (5) begin
            tick(1);
            pulses += int'(externalInterruptPulse === 1'b1);
        end
        chk(8'(e), 8'(pulses), "edge");
    endtask

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #5000000;
        bad_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(8));
        tick(6);
        check_idle();
        resetn = 1'b1;
        tick(3);
        check_idle();
        $display("Test reset done");
        repeat (60) begin
            {portADirectionIn, portBDirectionIn, keyPortDirectionIn, mixedPortDirectionIn,
                pullupOptionIn, keyReturnModeIn, keyControlModeIn, mixedControlModeIn,
                edgeSelectIn, segmentPortFunctionIn} = 30'($urandom);
            {portADataIn, portBDataIn, keyPortDataIn, mixedPortDataIn, timerOutput,
                sharedSegmentOutputs} = 19'($urandom);
            {extA, extB, extK, extM, extS} = 18'($urandom);
            apply();
            check_ports();
        end
        $display("Test random ports done");
        portADirectionIn = 4'hF;
        {portBDirectionIn, keyPortDirectionIn} = 6'h3F;
        pullupOptionIn = 3'h7;
        {enA, enB, enK} = 10'h000;
        apply();
        chk(8'h0F, {4'h0, portARead}, "float");
        chk(8'h3F, {2'h0, portBRead, keyPortRead}, "float bk");
        {enA, enB, enK} = 10'h3FF;
        $display("Test pull-up float done");
        mixedControlModeIn = 2'h2;
        mixedPortDirectionIn[1] = 1'b1;
        foreach (edges[i]) begin
            edgeSelectIn = 2'(edges[i]);
            extM[1] = 1'b0;
            apply();
            count_pulses(1'b1, edges[i] != 1);
            count_pulses(1'b0, edges[i] != 0);
        end
        $display("Test edge select done");
        resetn = 1'b0;
        tick(3);
        resetn = 1'b1;
        tick(3);
        check_idle();
        $display("Test mid reset done");
        give_verdict();
    end
endmodule // port_pin_control_tb_top
`default_nettype wire
